// ==== rtl/pss_sequencer.sv ====
/*
  phy strap release sequencer: sets pin pull states, turns off the boot
  option buffers, releases phy reset, closes the isolation switch and then
  hands pins to their application functions.
  assumes software on an AXI4-Lite bus starts the sequence after power-on
  reset; all pins are driven on the system clock.
*/
// Overview of operation
// RL1 - each phy reads every strap as one of four levels and adopts them at reset release.
// RL2 - only the lowest or highest strap level is ever presented on pins shared with the host.
// RL3 - boot option pins keep their power-on state except bits 6 and 7, which get pull-downs.
// RL4 - the pulls on the two pins carrying the first phy's straps are switched off.
// RL5 - all pulls on pins carrying the second phy's straps are off before phy reset release.
// RL6 - the first step drives the buffer-disable line as an output, high.
// RL7 - at least 100 us later the phy reset line is driven high as an enabled output.
// RL8 - a further 100 us later the isolation switch control is driven high.
// RL9 - pins go to application functions only after the isolation switch is on.
// RL10 - the second phy latches address 13 and otherwise matches the first phy.
// RL11 - both phys strap to mii mode with the 24 MHz reference clock.
// RL12 - each phy's first led is strapped lit on good link, dark on no link.
// RL13 - the boot buffers stay enabled, control low, until the sequencer turns them off.
// RL14 - the isolation switch control stays low until the sequencer drives it high.
// RL15 - each wait is a counter from the clock rate giving no less than the required delay.
`timescale 1ns/100ps
module pss_sequencer
  import pss_pkg::*;
#(
  parameter int unsigned BUF_OFF_CYC = BUF_OFF_WAIT_CYC,
  parameter int unsigned PHY_RST_CYC = PHY_RST_WAIT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // boot buffer disable line (high turns buffers off)
  output logic boot_buffer_disable_o,
  output logic boot_buffer_disable_oe,
  // phy reset release line (high releases both phys)
  output logic phy_reset_release_o,
  output logic phy_reset_release_oe,
  // isolation switch control (high closes switch)
  output logic isolation_switch_ctl_o,
  output logic isolation_switch_ctl_oe,
  // pin pull controls
  output logic [1:0] boot_option_pulldown_en,
  output logic [1:0] phy1_strap_pull_en,
  output logic [PHY2_STRAP_W-1:0] phy2_strap_pull_en,
  // hand-over to application pin functions
  output logic app_pins_en,
  output logic seq_done
);

  // register state
  logic start_q, start_d;
  logic [3:0] pull_q, pull_d;
  // axi write channel state
  logic aw_hold_q, aw_hold_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic w_hold_q, w_hold_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  // axi read channel state
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  // sequencer state
  pss_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic buf_off_q, buf_off_d;
  logic rst_rel_q, rst_rel_d;
  logic sw_on_q, sw_on_d;
  logic app_q, app_d;
  logic do_write;
  logic pulls_ready;

  // channel acceptance
  // a new write waits until the previous response has been taken
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // register file and bus next state
  always_comb begin
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d = w_hold_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    start_d = 1'b0;
    pull_d = pull_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (do_write) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      unique case (aw_addr_q[7:2])
        CTRL_OFS[7:2]: begin
          start_d = w_strb_q[0] && w_data_q[CTRL_START_BIT];
        end
        PULL_OFS[7:2]: begin
          // pulls are frozen once the sequence runs
          if (w_strb_q[0] && state_q == ST_IDLE) begin
            pull_d = w_data_q[3:0];
          end
        end
        STATUS_OFS[7:2]: begin
          bresp_d = RESP_OKAY;
        end
        default: begin
          bresp_d = RESP_SLVERR;
        end
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0000_0000;
      unique case (s_axi_araddr[7:2])
        CTRL_OFS[7:2]: begin
          rdata_d[CTRL_START_BIT] = (state_q != ST_IDLE);
        end
        STATUS_OFS[7:2]: begin
          rdata_d[ST_STATE_LSB +: 6] = state_q;
          rdata_d[ST_DONE_BIT] = app_q;
        end
        PULL_OFS[7:2]: begin
          rdata_d[3:0] = pull_q;
        end
        default: begin
          rresp_d = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // bus and register flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      start_q <= 1'b0;
      pull_q <= PULL_RESET;
    end else begin
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q <= w_hold_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      start_q <= start_d;
      pull_q <= pull_d;
    end
  end

  // pin pull states: pull_q bit set means the required setting is applied
  // start is refused unless every pull setting has been applied
  assign pulls_ready = pull_q[PULL_BOOT67_LSB +: 2] == 2'h3 && pull_q[PULL_PHY1_BIT]
                       && pull_q[PULL_PHY2_BIT];
  assign boot_option_pulldown_en = pull_q[PULL_BOOT67_LSB +: 2]; // RL3
  assign phy1_strap_pull_en = {2{!pull_q[PULL_PHY1_BIT]}}; // RL4
  assign phy2_strap_pull_en = {PHY2_STRAP_W{!pull_q[PULL_PHY2_BIT]}}; // RL5

  // sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    buf_off_d = buf_off_q;
    rst_rel_d = rst_rel_q;
    sw_on_d = sw_on_q;
    app_d = app_q;
    unique case (state_q)
      ST_IDLE: begin
        // start is refused until the phy strap pins no longer carry host pulls and boot bits 6 and 7 are pulled down
        if (start_q && pulls_ready) begin // RL5
          state_d = ST_BUF_OFF;
        end
      end
      ST_BUF_OFF: begin
        // the wait counts from the cycle the buffers turn off
        buf_off_d = 1'b1; // RL6
        cnt_d = CNT_W'(BUF_OFF_CYC - 1); // RL15
        state_d = ST_WAIT_RST;
      end
      ST_WAIT_RST: begin
        if (cnt_q == '0) begin
          rst_rel_d = 1'b1; // RL7
          cnt_d = CNT_W'(PHY_RST_CYC - 1); // RL15
          state_d = ST_WAIT_SW;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_WAIT_SW: begin
        if (cnt_q == '0) begin
          sw_on_d = 1'b1; // RL8
          state_d = ST_SW_ON;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_SW_ON: begin
        app_d = 1'b1; // RL9
        state_d = ST_APP;
      end
      ST_APP: begin
        // terminal: only reset restarts the sequence
        state_d = ST_APP;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // sequencer flops; reset leaves every line undriven so the board pulls hold it low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      buf_off_q <= 1'b0;
      rst_rel_q <= 1'b0;
      sw_on_q <= 1'b0;
      app_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      buf_off_q <= buf_off_d;
      rst_rel_q <= rst_rel_d;
      sw_on_q <= sw_on_d;
      app_q <= app_d;
    end
  end

  // pins are full-rail outputs only, undriven until their step
  assign boot_buffer_disable_o = buf_off_q; // RL2
  assign boot_buffer_disable_oe = buf_off_q; // RL13
  assign phy_reset_release_o = rst_rel_q;
  assign phy_reset_release_oe = rst_rel_q;
  assign isolation_switch_ctl_o = sw_on_q;
  assign isolation_switch_ctl_oe = sw_on_q; // RL14
  assign app_pins_en = app_q;
  assign seq_done = app_q;

endmodule

// ==== rtl/pss_pkg.sv ====
/*
  constants for the phy strap release sequencer: register map, field
  positions, reset values, timing counts and the sequencer state type.
  assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package pss_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BUF_OFF_WAIT_US = 100;
  localparam int unsigned PHY_RST_WAIT_US = 100;
  // least time is microseconds times whole cycles per microsecond, with no rounding up
  localparam int unsigned BUF_OFF_WAIT_CYC = (BUF_OFF_WAIT_US * (CLK_HZ / 1_000_000)) + 0;
  localparam int unsigned PHY_RST_WAIT_CYC = (PHY_RST_WAIT_US * (CLK_HZ / 1_000_000)) + 0;
  localparam int unsigned CNT_W = 16;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] PULL_OFS = 8'h08;

  // control fields
  localparam int unsigned CTRL_START_BIT = 0;
  // status fields
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_DONE_BIT = 8;
  // pull register fields: bits 1:0 pull-down on boot bits 6/7, bit 2 phy1 pulls,
  // bit 3 phy2 pulls
  localparam int unsigned PULL_BOOT67_LSB = 0;
  localparam int unsigned PULL_PHY1_BIT = 2;
  localparam int unsigned PULL_PHY2_BIT = 3;
  localparam logic [3:0] PULL_RESET = 4'h0;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // strap pin counts
  localparam int unsigned BOOT_W = 16;
  localparam int unsigned PHY2_STRAP_W = 15;

  // sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_BUF_OFF = 6'h02,
    ST_WAIT_RST = 6'h04,
    ST_WAIT_SW = 6'h08,
    ST_SW_ON = 6'h10,
    ST_APP = 6'h20
  } pss_state_t;
endpackage

// ==== verif/pss_properties.sv ====
/*
  checker for the sequencer pins: order and spacing of the release steps,
  pull states around phy reset release.
  assumes it is bound to pss_sequencer and sees only its ports.
*/
`timescale 1ns/100ps
module pss_checker
  import pss_pkg::*;
#(
  parameter int unsigned BUF_OFF_CYC = BUF_OFF_WAIT_CYC,
  parameter int unsigned PHY_RST_CYC = PHY_RST_WAIT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sequenced pins
  input wire logic boot_buffer_disable_o,
  input wire logic boot_buffer_disable_oe,
  input wire logic phy_reset_release_o,
  input wire logic phy_reset_release_oe,
  input wire logic isolation_switch_ctl_o,
  input wire logic isolation_switch_ctl_oe,
  // pulls and hand-over
  input wire logic [1:0] boot_option_pulldown_en,
  input wire logic [1:0] phy1_strap_pull_en,
  input wire logic [PHY2_STRAP_W-1:0] phy2_strap_pull_en,
  input wire logic app_pins_en
);
  // cycles each line has stood high before the next step
  logic [31:0] buf_cyc_q;
  logic [31:0] rst_cyc_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // wait counters keep the full-length waits cheap to check
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      buf_cyc_q <= 32'h0000_0000;
      rst_cyc_q <= 32'h0000_0000;
    end else begin
      if (boot_buffer_disable_o && !phy_reset_release_o) begin
        buf_cyc_q <= buf_cyc_q + 32'h0000_0001;
      end
      if (phy_reset_release_o && !isolation_switch_ctl_o) begin
        rst_cyc_q <= rst_cyc_q + 32'h0000_0001;
      end
    end
  end
  // the two timed steps of the sequence
  sequence rst_rise;
    $rose(phy_reset_release_o);
  endsequence
  sequence sw_rise;
    $rose(isolation_switch_ctl_o);
  endsequence
  // step order and exact wait lengths
  buf_first_a: assert property ($rose(boot_buffer_disable_o) |->
    boot_buffer_disable_oe && !phy_reset_release_o)
    else $error("buffer disable step out of order");
  rst_wait_a: assert property (rst_rise |-> buf_cyc_q == BUF_OFF_CYC)
    else $error("phy reset released at wrong time");
  sw_wait_a: assert property (sw_rise |-> rst_cyc_q == PHY_RST_CYC)
    else $error("isolation switch closed at wrong time");
  app_after_a: assert property ($rose(app_pins_en) |->
    $past(isolation_switch_ctl_o) && !$past(isolation_switch_ctl_o, 2))
    else $error("application hand-over at wrong time");
  // lines stay low until their step
  sw_hold_a: assert property (!phy_reset_release_o |->
    !isolation_switch_ctl_o && !isolation_switch_ctl_oe)
    else $error("switch closed before phy reset release");
  buf_hold_a: assert property (!boot_buffer_disable_oe |->
    !boot_buffer_disable_o && !phy_reset_release_oe)
    else $error("buffers not enabled before sequence");
  // pull states while straps are latched
  phy1_pull_a: assert property (phy_reset_release_oe |-> phy1_strap_pull_en == 2'h0)
    else $error("phy1 strap pulls on at reset release");
  phy2_pull_a: assert property (phy_reset_release_oe |-> phy2_strap_pull_en == '0)
    else $error("phy2 strap pulls on at reset release");
  boot_pull_a: assert property (boot_buffer_disable_o |-> boot_option_pulldown_en == 2'h3)
    else $error("boot bits 6 and 7 not pulled down");
endmodule

bind pss_sequencer pss_checker #(.BUF_OFF_CYC(BUF_OFF_CYC), .PHY_RST_CYC(PHY_RST_CYC))
  pss_checker_i (
  .clk(clk),
  .rst_n(rst_n),
  .boot_buffer_disable_o(boot_buffer_disable_o),
  .boot_buffer_disable_oe(boot_buffer_disable_oe),
  .phy_reset_release_o(phy_reset_release_o),
  .phy_reset_release_oe(phy_reset_release_oe),
  .isolation_switch_ctl_o(isolation_switch_ctl_o),
  .isolation_switch_ctl_oe(isolation_switch_ctl_oe),
  .boot_option_pulldown_en(boot_option_pulldown_en),
  .phy1_strap_pull_en(phy1_strap_pull_en),
  .phy2_strap_pull_en(phy2_strap_pull_en),
  .app_pins_en(app_pins_en)
);

// ==== verif/pss_phy_pair.sv ====
/*
  model of the two phys: each latches its strap word on reset release.
  assumes the host reset line and the host pull enables on strap pins.
*/
`timescale 1ns/100ps
module pss_phy_pair #(
  parameter logic [6:0] STRAP1 = 7'h61,
  parameter logic [6:0] STRAP2 = 7'h6D
) (
  // clock and reset line
  input wire logic clk,
  input wire logic rst_rel,
  // host pull enables on strap pins
  input wire logic [1:0] p1_pull,
  input wire logic [14:0] p2_pull,
  // latched word: led mode, mii mode, address
  output logic [6:0] cfg1,
  output logic [6:0] cfg2
);
  logic rel_q = 1'b0;
  // a live host pull leaves a mid level, so the latched word is lost
  always_ff @(posedge clk) begin
    rel_q <= rst_rel;
    if (rst_rel && !rel_q) begin
      cfg1 <= |p1_pull ? 7'h00 : STRAP1;
      cfg2 <= |p2_pull ? 7'h00 : STRAP2;
    end
  end
endmodule

// ==== verif/test_phy_strap_release_sequencer.sv ====
/*
  testbench: register accesses over axi4-lite, sequence timing, pull states.
  assumes pss_sequencer with short waits of 4 cycles and the phy model.
*/
`timescale 1ns/100ps
module test_phy_strap_release_sequencer
  import pss_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, boot_option_pulldown_en, phy1_strap_pull_en;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic boot_buffer_disable_o, boot_buffer_disable_oe, phy_reset_release_o;
  logic phy_reset_release_oe, isolation_switch_ctl_o, isolation_switch_ctl_oe;
  logic app_pins_en, seq_done;
  logic [14:0] phy2_strap_pull_en;
  logic [6:0] cfg1, cfg2;
  int err_count = 0, compares = 0, cyc = 0;
  time t_buf = 0, t_rst = 0, t_sw = 0, t_app = 0;

  pss_sequencer #(.BUF_OFF_CYC(4), .PHY_RST_CYC(4)) pss_sequencer_i (.*);
  pss_phy_pair pss_phy_pair_i (.clk(clk), .rst_rel(phy_reset_release_o),
    .p1_pull(phy1_strap_pull_en), .p2_pull(phy2_strap_pull_en), .cfg1(cfg1), .cfg2(cfg2));

  // clock, hang limit and step times
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      end_of_test();
    end
  end
  always @(posedge boot_buffer_disable_o) t_buf = $time;
  always @(posedge phy_reset_release_o) t_rst = $time;
  always @(posedge isolation_switch_ctl_o) t_sw = $time;
  always @(posedge app_pins_en) t_app = $time;

  // compare one value and count a mismatch
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, b;
    b = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge clk);
      ha = s_axi_awready;
      hw = s_axi_wready;
      b = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk(rsp, er);
  endtask

  // read: address offered, data and response taken with rvalid
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic h, r;
    r = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r) begin
      @(negedge clk);
      h = s_axi_arready;
      r = s_axi_rvalid;
      rd_d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
      if (h) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(rd_d, e);
    chk(rsp, er);
  endtask

  // verdict and end of run
  task automatic end_of_test();
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({boot_buffer_disable_o, boot_buffer_disable_oe, phy_reset_release_o,
      isolation_switch_ctl_o, isolation_switch_ctl_oe, app_pins_en}, 32'h0);
    chk({phy2_strap_pull_en, phy1_strap_pull_en, boot_option_pulldown_en}, 32'h7FFFC);
    rd(PULL_OFS, 32'h0, RESP_OKAY);
    rd(8'h0C, 32'h0, RESP_SLVERR);
    wr(CTRL_OFS, 32'h1, RESP_OKAY);
    rd(STATUS_OFS, 32'h1, RESP_OKAY);
    wr(PULL_OFS, 32'hF, RESP_OKAY);
    chk({phy2_strap_pull_en, phy1_strap_pull_en, boot_option_pulldown_en}, 32'h3);
    wr(CTRL_OFS, 32'h1, RESP_OKAY);
    for (int i = 0; i < 100 && app_pins_en !== 1'b1; i++) @(negedge clk);
    chk(32'(t_rst - t_buf), 32'h28);
    chk(32'(t_sw - t_rst), 32'h28);
    chk(32'(t_app - t_sw), 32'h0A);
    chk({boot_buffer_disable_oe, phy_reset_release_oe, isolation_switch_ctl_oe,
      seq_done}, 32'hF);
    rd(STATUS_OFS, 32'h120, RESP_OKAY);
    rd(CTRL_OFS, 32'h1, RESP_OKAY);
    wr(PULL_OFS, 32'h0, RESP_OKAY);
    rd(PULL_OFS, 32'hF, RESP_OKAY);
    chk(cfg1, 32'h61);
    chk(cfg2, 32'h6D);
    // a second reset returns every line to its power-on state
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({boot_buffer_disable_o, boot_buffer_disable_oe, phy_reset_release_o,
      isolation_switch_ctl_o, isolation_switch_ctl_oe, app_pins_en}, 32'h0);
    rd(STATUS_OFS, 32'h1, RESP_OKAY);
    rd(PULL_OFS, 32'h0, RESP_OKAY);
    end_of_test();
  end
endmodule
